// ==== rtl/bridge_timing_pkg.sv ====
// Constants and types shared by the bridge timing design.
// Assumes a 100 MHz system clock.
package bridge_timing_pkg;
   // ----------------------------------------------------------------
   // Clock and time base
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int UNIT_TIME_NS = 37000;
   localparam int UNIT_CYCLES = (UNIT_TIME_NS + CLK_PERIOD_NS - 1) /
                                CLK_PERIOD_NS;
   localparam int UNIT_W = $clog2(UNIT_CYCLES);
   localparam logic [UNIT_W-1:0] UNIT_LAST = UNIT_W'(UNIT_CYCLES - 1);
   localparam int PROC_TIME_NS = 1000000;
   localparam int PROC_CYCLES = (PROC_TIME_NS + CLK_PERIOD_NS - 1) /
                                CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Cycle formula factors
   // ----------------------------------------------------------------
   localparam int BIT_BASE_UNITS = 32;
   localparam int AUTO_MULT = 3;
   localparam int READ_MULT = 27;
   localparam int WRITE_MULT = 39;
   localparam int SINGLE_TARGETS = 1;
   localparam int MULT_W = 6;

   // ----------------------------------------------------------------
   // Default widths
   // ----------------------------------------------------------------
   localparam int BIT_POINTS_W = 11;
   localparam int WORD_LEN_W = 16;
   localparam int BIT_W = 16;
   localparam int WORD_W = 16;
   localparam int ID_W = 8;
   localparam int FIFO_DEPTH = 16;

   typedef enum logic [1:0] {
      p_idle = 2'b01,
      p_run = 2'b10
   } param_state_t;
endpackage

// ==== rtl/stream_if.sv ====
// Valid/ready word stream between the bridge and its buffer.
// Assumes both ends share one clock.
`timescale 1ns/100ps
interface stream_if #(parameter int WIDTH = 16);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ==== rtl/word_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/100ps
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic mclk,
   input wire logic rst_b,
   stream_if.snk fill,
   stream_if.src drain
);
   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH)
         $error("word_fifo depth must be a power of two");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic full;
   logic empty;
   logic push;
   logic pop;

   // ----------------------------------------------------------------
   // Flags
   // ----------------------------------------------------------------
   assign full = (wr_ptr[AW] != rd_ptr[AW]) &&
                 (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign empty = (wr_ptr == rd_ptr);
   assign fill.ready = ~full;
   assign drain.valid = ~empty;
   assign drain.data = mem[rd_ptr[AW-1:0]];
   assign push = fill.valid & ~full;
   assign pop = drain.ready & ~empty;

   // ----------------------------------------------------------------
   // Storage and pointers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (push)
         mem[wr_ptr[AW-1:0]] <= fill.data;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         wr_ptr <= '0;
      else if (push)
         wr_ptr <= wr_ptr + 1'b1;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         rd_ptr <= '0;
      else if (pop)
         rd_ptr <= rd_ptr + 1'b1;
   end
endmodule

// ==== rtl/fieldbus_bridge_update_timing.sv ====
// Timing engine of the field-bus bridge: data update, response delays
// and parameter access scheduling.
// Assumes frame, bit and upstream inputs come from logic on mclk.
// Function
// - Word main and check values come from one frame and are sampled within one word cycle.
// - A word frame without abnormality updates the word input area within one word cycle while the buffer has room.
// - Field transmission takes two bit cycles for bit data and one word cycle for word data.
// - Bridge processing takes 1.0 ms in each direction.
// - Input delay is slave input time plus transmission plus processing.
// - Output delay is processing plus transmission plus slave output time.
// - Parameter sync runs on its own schedule apart from cyclic data.
// - Auto-updated parameters refresh every connected IDs times cycle times 3.
// - A parameter read takes target IDs times bit cycles times 27.
// - A parameter write takes target IDs times bit cycles times 39.
// - Single access targets one ID, batch access the registered ID count.
// - A bit cycle lasts half the bit points plus 32, times 37 us.
`timescale 1ns/100ps
module fieldbus_bridge_update_timing #(
   parameter int PROC_CYCLES = bridge_timing_pkg::PROC_CYCLES,
   parameter int UNIT_CYCLES = bridge_timing_pkg::UNIT_CYCLES,
   parameter int BIT_POINTS_W = bridge_timing_pkg::BIT_POINTS_W,
   parameter int WORD_LEN_W = bridge_timing_pkg::WORD_LEN_W,
   parameter int BIT_W = bridge_timing_pkg::BIT_W,
   parameter int WORD_W = bridge_timing_pkg::WORD_W,
   parameter int ID_W = bridge_timing_pkg::ID_W,
   parameter int FIFO_DEPTH = bridge_timing_pkg::FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [BIT_POINTS_W-1:0] bit_points,
   input wire logic [WORD_LEN_W-1:0] word_len,
   input wire logic [BIT_W-1:0] bit_in,
   input wire logic frame_valid,
   input wire logic [WORD_W-1:0] frame_main,
   input wire logic [WORD_W-1:0] frame_check,
   input wire logic up_ready,
   input wire logic up_out_valid,
   input wire logic [WORD_W-1:0] up_out_word,
   input wire logic param_req,
   input wire logic param_write,
   input wire logic param_batch,
   input wire logic [ID_W-1:0] ids_registered,
   input wire logic [ID_W-1:0] ids_connected,
   output logic [BIT_W-1:0] bit_area,
   output logic [WORD_W-1:0] word_in_area,
   output logic word_update,
   output logic word_abnormal,
   output logic up_valid,
   output logic [WORD_W-1:0] up_word,
   output logic up_out_ready,
   output logic field_out_valid,
   output logic [WORD_W-1:0] field_out_word,
   output logic param_busy,
   output logic param_done,
   output logic auto_refresh
);
   localparam int PT_W = $clog2(PROC_CYCLES + 1);
   localparam int UN_W = $clog2(UNIT_CYCLES);
   localparam logic [UN_W-1:0] UNIT_END = UN_W'(UNIT_CYCLES - 1);
   localparam int RM_W = ID_W + bridge_timing_pkg::MULT_W;
   localparam int AU_W = ID_W + 2;
   localparam logic [PT_W-1:0] PROC_LAST = PT_W'(PROC_CYCLES - 1);

   initial begin
      if (PROC_CYCLES < 1 || UNIT_CYCLES < 2 || ID_W < 1 ||
          BIT_POINTS_W < 7)
         $error("fieldbus_bridge_update_timing: bad parameters");
   end

   // ----------------------------------------------------------------
   // Time base and cycle ticks
   // ----------------------------------------------------------------
   logic [UN_W-1:0] unit_cnt;
   logic unit_tick;
   logic [BIT_POINTS_W-1:0] bit_len;
   logic [BIT_POINTS_W-1:0] bit_cnt;
   logic bit_tick;
   logic [WORD_LEN_W-1:0] word_cnt;
   logic word_tick;

   assign unit_tick = (unit_cnt == UNIT_END);
   assign bit_len = {1'b0, bit_points[BIT_POINTS_W-1:1]} +
                    BIT_POINTS_W'(bridge_timing_pkg::BIT_BASE_UNITS);
   assign bit_tick = unit_tick && (bit_cnt == bit_len - 1'b1);
   assign word_tick = unit_tick &&
                      (word_len == '0 || word_cnt == word_len - 1'b1);

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         unit_cnt <= '0;
      else if (unit_tick)
         unit_cnt <= '0;
      else
         unit_cnt <= unit_cnt + 1'b1;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         bit_cnt <= '0;
      else if (bit_tick)
         bit_cnt <= '0;
      else if (unit_tick)
         bit_cnt <= bit_cnt + 1'b1;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         word_cnt <= '0;
      else if (word_tick)
         word_cnt <= '0;
      else if (unit_tick)
         word_cnt <= word_cnt + 1'b1;
   end

   // ----------------------------------------------------------------
   // Bit input, taken after two equal samples
   // ----------------------------------------------------------------
   logic [BIT_W-1:0] bit_prev;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         bit_prev <= '0;
         bit_area <= '0;
      end else if (bit_tick) begin
         bit_prev <= bit_in;
         if (bit_in == bit_prev)
            bit_area <= bit_in;
      end
   end

   // ----------------------------------------------------------------
   // Word input sampling
   // ----------------------------------------------------------------
   logic frame_good;
   logic pend;
   logic [WORD_W-1:0] pend_word;
   logic take;

   stream_if #(.WIDTH(WORD_W)) fill_s ();
   stream_if #(.WIDTH(WORD_W)) drain_s ();

   assign frame_good = frame_valid && (frame_main == frame_check);
   assign take = word_tick && pend && fill_s.ready;
   assign fill_s.valid = take;
   assign fill_s.data = pend_word;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         pend <= 1'b0;
      else if (frame_good)
         pend <= 1'b1;
      else if (take)
         pend <= 1'b0;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         pend_word <= '0;
      else if (frame_good)
         pend_word <= frame_main;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         word_in_area <= '0;
         word_update <= 1'b0;
      end else begin
         word_update <= take;
         if (take)
            word_in_area <= pend_word;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         word_abnormal <= 1'b0;
      else
         word_abnormal <= frame_valid && (frame_main != frame_check);
   end

   word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk(mclk),
      .rst_b(rst_b),
      .fill(fill_s),
      .drain(drain_s)
   );

   // ----------------------------------------------------------------
   // Input processing stage toward upstream
   // ----------------------------------------------------------------
   logic in_busy;
   logic [PT_W-1:0] in_tmr;
   logic in_start;

   assign in_start = drain_s.valid && !in_busy && !up_valid;
   assign drain_s.ready = in_busy && (in_tmr == '0);

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         in_busy <= 1'b0;
         in_tmr <= '0;
      end else if (in_start) begin
         in_busy <= 1'b1;
         in_tmr <= PROC_LAST;
      end else if (in_busy && in_tmr == '0) begin
         in_busy <= 1'b0;
      end else if (in_busy) begin
         in_tmr <= in_tmr - 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         up_valid <= 1'b0;
         up_word <= '0;
      end else if (drain_s.ready) begin
         up_valid <= 1'b1;
         up_word <= drain_s.data;
      end else if (up_ready) begin
         up_valid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Output path: processing, then next word cycle
   // ----------------------------------------------------------------
   logic out_busy;
   logic out_wait;
   logic [PT_W-1:0] out_tmr;
   logic [WORD_W-1:0] out_hold;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         out_busy <= 1'b0;
         out_wait <= 1'b0;
         out_tmr <= '0;
         out_hold <= '0;
         up_out_ready <= 1'b0;
      end else begin
         up_out_ready <= !out_busy && !(up_out_valid && up_out_ready);
         if (up_out_valid && up_out_ready) begin
            out_busy <= 1'b1;
            out_tmr <= PROC_LAST;
            out_hold <= up_out_word;
         end else if (out_busy && !out_wait && out_tmr == '0) begin
            out_wait <= 1'b1;
         end else if (out_busy && !out_wait) begin
            out_tmr <= out_tmr - 1'b1;
         end else if (out_wait && word_tick) begin
            out_wait <= 1'b0;
            out_busy <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         field_out_valid <= 1'b0;
         field_out_word <= '0;
      end else begin
         field_out_valid <= out_wait && word_tick;
         if (out_wait && word_tick)
            field_out_word <= out_hold;
      end
   end

   // ----------------------------------------------------------------
   // Parameter access, on bit cycles
   // ----------------------------------------------------------------
   bridge_timing_pkg::param_state_t pstate;
   logic [ID_W-1:0] targets;
   logic [RM_W-1:0] mult;
   logic [RM_W-1:0] remain;
   logic p_start;

   assign targets = param_batch ? ids_registered :
                    ID_W'(bridge_timing_pkg::SINGLE_TARGETS);
   assign mult = param_write ?
                 RM_W'(bridge_timing_pkg::WRITE_MULT) :
                 RM_W'(bridge_timing_pkg::READ_MULT);
   assign p_start = param_req && (pstate == bridge_timing_pkg::p_idle) &&
                    (targets != '0);

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pstate <= bridge_timing_pkg::p_idle;
         remain <= '0;
         param_busy <= 1'b0;
         param_done <= 1'b0;
      end else begin
         param_done <= 1'b0;
         case (pstate)
            bridge_timing_pkg::p_idle: begin
               if (p_start) begin
                  remain <= RM_W'(RM_W'(targets) * mult);
                  pstate <= bridge_timing_pkg::p_run;
                  param_busy <= 1'b1;
               end
            end
            bridge_timing_pkg::p_run: begin
               if (bit_tick && remain == RM_W'(1)) begin
                  pstate <= bridge_timing_pkg::p_idle;
                  param_busy <= 1'b0;
                  param_done <= 1'b1;
               end else if (bit_tick) begin
                  remain <= remain - 1'b1;
               end
            end
            default: begin
               pstate <= bridge_timing_pkg::p_idle;
               param_busy <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Automatic parameter refresh
   // ----------------------------------------------------------------
   logic [AU_W-1:0] auto_cnt;
   logic [AU_W-1:0] auto_last;

   assign auto_last = AU_W'(AU_W'(ids_connected) *
                      AU_W'(bridge_timing_pkg::AUTO_MULT)) - 1'b1;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         auto_cnt <= '0;
         auto_refresh <= 1'b0;
      end else begin
         auto_refresh <= 1'b0;
         if (ids_connected == '0) begin
            auto_cnt <= '0;
         end else if (bit_tick && auto_cnt >= auto_last) begin
            auto_cnt <= '0;
            auto_refresh <= 1'b1;
         end else if (bit_tick) begin
            auto_cnt <= auto_cnt + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   word_sample_a: assert property (
      word_update |-> $past(word_tick) && word_in_area == $past(pend_word))
      else $error("word area updated off a word tick");
   word_bound_a: assert property (
      pend && word_tick && fill_s.ready |=> word_update)
      else $error("good word not taken at word tick");
   abnormal_drop_a: assert property (
      frame_valid && frame_main != frame_check && !pend |=> !pend)
      else $error("abnormal word frame was kept");
   bit_twice_a: assert property (
      bit_tick && bit_in == bit_prev |=> bit_area == $past(bit_in))
      else $error("bit area not updated after two equal samples");
   proc_load_a: assert property (
      in_start |=> in_busy && in_tmr == PROC_LAST)
      else $error("input processing timer wrong");
   up_after_proc_a: assert property (
      $rose(up_valid) |-> $past(in_busy) && $past(in_tmr) == '0)
      else $error("upstream word before processing time");
   field_out_a: assert property (
      field_out_valid |-> $past(out_wait) && $past(word_tick))
      else $error("field output off word cycle");
   read_len_a: assert property (
      p_start && !param_write && !param_batch |=>
      remain == RM_W'(bridge_timing_pkg::READ_MULT))
      else $error("single read length wrong");
   write_len_a: assert property (
      p_start && param_write |=>
      remain == RM_W'($past(targets) * bridge_timing_pkg::WRITE_MULT))
      else $error("write length wrong");
   auto_period_a: assert property (
      auto_refresh |-> $past(bit_tick) && $past(auto_cnt) >= $past(auto_last))
      else $error("auto refresh off schedule");
   bit_len_a: assert property (
      bit_tick |-> unit_tick && bit_cnt == BIT_POINTS_W'(bit_points / 2 +
      bridge_timing_pkg::BIT_BASE_UNITS - 1))
      else $error("bit cycle length wrong");
endmodule

// ==== bench/field_slave_model.sv ====
// Behavioural field-bus slave side: word frames in, output words out.
// Assumes the bench calls send_frame just after a rising mclk edge.
`timescale 1ns/100ps
module field_slave_model (
   input wire logic mclk,
   input wire logic field_out_valid,
   input wire logic [bridge_timing_pkg::WORD_W-1:0] field_out_word,
   output logic frame_valid,
   output logic [bridge_timing_pkg::WORD_W-1:0] frame_main,
   output logic [bridge_timing_pkg::WORD_W-1:0] frame_check,
   output logic [bridge_timing_pkg::BIT_W-1:0] bit_in
);
   // ----------------------------------------------------------------
   // Frame drive
   // ----------------------------------------------------------------
   logic [bridge_timing_pkg::WORD_W-1:0] applied;
   int applied_count;

   initial begin
      frame_valid = 1'b0;
      frame_main = 16'h0000;
      frame_check = 16'hffff;
      bit_in = 16'h00a5;
      applied = 16'h0000;
      applied_count = 0;
   end

   // Main and copy travel in one frame, held to the sampling edge
   task automatic send_frame(input logic [15:0] main,
                             input logic [15:0] copy);
      frame_valid = 1'b1;
      frame_main = main;
      frame_check = copy;
      @(posedge mclk);
      #1;
      frame_valid = 1'b0;
      frame_main = ~main;
      frame_check = ~copy;
   endtask

   // ----------------------------------------------------------------
   // Output apply
   // ----------------------------------------------------------------
   // Slave applies each output word itself and counts it
   always @(posedge mclk) begin
      if (field_out_valid === 1'b1) begin
         applied <= field_out_word;
         applied_count <= applied_count + 1;
      end
   end
endmodule

// ==== bench/fieldbus_bridge_update_timing_test.sv ====
// Self-checking bench for the bridge timing block.
// Assumes shortened processing and unit counts and a 100 MHz clock.
`timescale 1ns/100ps
module fieldbus_bridge_update_timing_test;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   localparam int proc_cycles = 20;
   localparam int unit = 10;
   logic mclk, rst_b, frame_valid, up_ready, up_out_valid;
   logic param_req, param_write, param_batch;
   logic [10:0] bit_points;
   logic [15:0] word_len, bit_in, frame_main, frame_check;
   logic [15:0] up_out_word, bit_area, word_in_area, up_word;
   logic [15:0] field_out_word;
   logic [7:0] ids_registered, ids_connected;
   logic word_update, word_abnormal, up_valid, up_out_ready;
   logic field_out_valid, param_busy, param_done, auto_refresh;
   int err_total, total_checks;

   fieldbus_bridge_update_timing #(.PROC_CYCLES(proc_cycles),
      .UNIT_CYCLES(unit)) dut (
      .mclk(mclk), .rst_b(rst_b), .bit_points(bit_points),
      .word_len(word_len), .bit_in(bit_in), .frame_valid(frame_valid),
      .frame_main(frame_main), .frame_check(frame_check),
      .up_ready(up_ready), .up_out_valid(up_out_valid),
      .up_out_word(up_out_word), .param_req(param_req),
      .param_write(param_write), .param_batch(param_batch),
      .ids_registered(ids_registered), .ids_connected(ids_connected),
      .bit_area(bit_area), .word_in_area(word_in_area),
      .word_update(word_update), .word_abnormal(word_abnormal),
      .up_valid(up_valid), .up_word(up_word),
      .up_out_ready(up_out_ready), .field_out_valid(field_out_valid),
      .field_out_word(field_out_word), .param_busy(param_busy),
      .param_done(param_done), .auto_refresh(auto_refresh));

   field_slave_model partner (
      .mclk(mclk), .field_out_valid(field_out_valid),
      .field_out_word(field_out_word), .frame_valid(frame_valid),
      .frame_main(frame_main), .frame_check(frame_check),
      .bit_in(bit_in));

   always #5 mclk = ~mclk;

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tick();
      @(posedge mclk);
      #1;
   endtask

   function automatic logic flag(input int k);
      case (k)
         0: return word_update;
         1: return up_valid;
         2: return field_out_valid;
         3: return word_abnormal;
         default: return up_out_ready;
      endcase
   endfunction

   task automatic wait_on(input int k, input int lim, output int n);
      n = 0;
      while (flag(k) !== 1'b1) begin
         tick();
         n++;
         if (n > lim) begin
            err_total++;
            $display("unexpected timeout flag %0d expected 1 seen 0", k);
            end_of_test();
         end
      end
   endtask

   task automatic count_updates(input int cycles, output int c);
      c = 0;
      repeat (cycles) begin
         tick();
         if (word_update === 1'b1) c++;
      end
   endtask

   task automatic do_reset(input logic [15:0] wl);
      rst_b = 1'b0;
      word_len = wl;
      repeat (4) tick();
      rst_b = 1'b1;
      repeat (2) tick();
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic word_input(input logic [15:0] wl, input logic [15:0] v);
      int n;
      do_reset(wl);
      up_ready = 1'b0;
      partner.send_frame(v, v);
      wait_on(0, wl * unit + 2, n);
      check("word latency", 32'(n <= wl * unit + 1), 32'h1);
      check("word_in_area", word_in_area, v);
      wait_on(1, proc_cycles + 10, n);
      check("proc delay", 32'(n >= proc_cycles), 32'h1);
      check("up_word", up_word, v);
      repeat (3) tick();
      check("up_valid held", up_valid, 1'b1);
      up_ready = 1'b1;
      tick();
      up_ready = 1'b0;
      check("up_valid clear", up_valid, 1'b0);
   endtask

   task automatic bad_frame();
      int n;
      int c;
      do_reset(16'h0001);
      partner.send_frame(16'h1234, 16'h1235);
      wait_on(3, 3, n);
      tick();
      check("abnormal pulse", word_abnormal, 1'b0);
      count_updates(unit + 2, c);
      check("dropped frame", c, 32'h0);
      check("area kept", word_in_area, 16'h0000);
   endtask

   task automatic fill_drain();
      int n;
      int c;
      int got;
      up_ready = 1'b0;
      for (int k = 0; k < 18; k++) begin
         partner.send_frame(16'hdead, 16'hdead);
         tick();
         partner.send_frame(16'h0100 + k, 16'h0100 + k);
         if (k < 17) begin
            wait_on(0, unit + 2, n);
            check("latest wins", word_in_area, 16'h0100 + k);
         end else begin
            count_updates(unit + 2, c);
            check("full buffer", c, 32'h0);
         end
      end
      up_ready = 1'b1;
      got = 0;
      n = 0;
      while (got < 18) begin
         if (up_valid === 1'b1) begin
            check("drain order", up_word, 16'h0100 + got);
            got++;
         end
         tick();
         n++;
         if (n > 2 * unit + 18 * (proc_cycles + 10)) begin
            err_total++;
            $display("unexpected drain count expected 18 seen %0d", got);
            end_of_test();
         end
      end
      check("last word", word_in_area, 16'h0111);
   endtask

   task automatic out_word(input logic [15:0] v);
      int n;
      int a0;
      a0 = partner.applied_count;
      up_out_valid = 1'b1;
      up_out_word = v;
      wait_on(4, 3 * unit, n);
      tick();
      up_out_valid = 1'b0;
      up_out_word = ~v;
      tick();
      check("out refused", up_out_ready, 1'b0);
      wait_on(2, proc_cycles + unit + 4, n);
      check("out delay", 32'(n >= proc_cycles - 2), 32'h1);
      check("field word", field_out_word, v);
      tick();
      check("slave applied", partner.applied, v);
      check("applied count", partner.applied_count, a0 + 1);
   endtask

   task automatic param_mode(input logic [1:0] m, input logic [7:0] ids);
      do_reset(16'h0001);
      ids_registered = ids;
      param_write = m[0];
      param_batch = m[1];
      param_req = 1'b1;
      tick();
      param_req = 1'b0;
      tick();
      check("param busy", param_busy, 1'(ids != 0));
      repeat (300) tick();
      check("param early", param_done, 1'b0);
      check("param held", param_busy, 1'(ids != 0));
   endtask

   task automatic param_timing();
      int n;
      int r;
      int bc;
      bc = (bit_points / 2 + 32) * unit;
      do_reset(16'h0001);
      param_write = 1'b0;
      param_batch = 1'b0;
      param_req = 1'b1;
      tick();
      param_req = 1'b0;
      n = 0;
      r = 0;
      while (param_done !== 1'b1) begin
         tick();
         n++;
         if (auto_refresh === 1'b1) r++;
         if (n > 27 * bc) begin
            err_total++;
            $display("unexpected param_done expected 1 seen 0");
            end_of_test();
         end
      end
      check("read time", 32'(n > 26 * bc && n <= 27 * bc), 32'h1);
      check("bit cycle", 32'(bc), 32'(32 * unit));
      check("refresh count", r, 32'h9);
      check("bit area", bit_area, 16'h00a5);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      rst_b = 1'b0;
      bit_points = 11'h000;
      word_len = 16'h0001;
      up_ready = 1'b0;
      up_out_valid = 1'b0;
      up_out_word = 16'h0000;
      param_req = 1'b0;
      param_write = 1'b0;
      param_batch = 1'b0;
      ids_registered = 8'h02;
      ids_connected = 8'h01;
      err_total = 0;
      total_checks = 0;
      #1;
      word_input(16'h0002, 16'hc3c3);
      bad_frame();
      fill_drain();
      out_word(16'h5aa5);
      out_word(16'hffff);
      for (int m = 0; m < 4; m++) begin
         param_mode(2'(m), 8'h02);
      end
      param_mode(2'b10, 8'h00);
      param_timing();
      end_of_test();
   end
endmodule
